// File: design/pdbm_defines.svh
`ifndef PDBM_DEFINES_SVH
`define PDBM_DEFINES_SVH

// ==========================================================
// Register map and field layout
`define PDBM_REG_PWM_CFG 8'h12
`define PDBM_CFG_RESET 8'h00
`define PDBM_CFG_WR_MASK 8'hDC
`define PDBM_CFG_RATE_HI 7
`define PDBM_CFG_RATE_LO 6
`define PDBM_CFG_HYST_HI 4
`define PDBM_CFG_HYST_LO 2

// ==========================================================
// Clock and sample-rate generation
`define PDBM_CLK_FREQ_MHZ 100
`define PDBM_RATE_ACC_WRAP 10'h3E8
`define PDBM_RATE_INC_SLOW 10'h008
`define PDBM_RATE_INC_MID 10'h028
`define PDBM_RATE_INC_FAST 10'h0F0

// ==========================================================
// Missing-pulse timeouts in microseconds
`define PDBM_TMO_SLOW_US 25000
`define PDBM_TMO_MID_US 3000
`define PDBM_TMO_FAST_US 600

// ==========================================================
// Mapping constants, currents in nA
`define PDBM_CODE_MAX 11'h7FF
`define PDBM_LIN_OFFSET_NA 25'h00093AE
`define PDBM_LIN_SLOPE_NA 25'h0002FA3
`define PDBM_EXP_BASE_NA 48'h00000000C350
`define PDBM_EXP_LOG2_Q16 20'h0011F
`define PDBM_LN2_Q16 60'h00000000000B172

`endif

// File: design/pdbm_exp_rom.sv
`timescale 1ns/1ps

// ==========================================================
// Fractional power-of-two table: 2^(i/32) in unsigned Q1.16.
module pdbm_exp_rom (
	input wire logic clk,
	input wire logic [4:0] addr,
	output logic [16:0] rdata
);

	function automatic logic [16:0] pdbm_pow2_frac(input logic [4:0] i);
		case (i)
			5'h00: pdbm_pow2_frac = 17'h10000;
			5'h01: pdbm_pow2_frac = 17'h1059B;
			5'h02: pdbm_pow2_frac = 17'h10B56;
			5'h03: pdbm_pow2_frac = 17'h11130;
			5'h04: pdbm_pow2_frac = 17'h1172C;
			5'h05: pdbm_pow2_frac = 17'h11D48;
			5'h06: pdbm_pow2_frac = 17'h12388;
			5'h07: pdbm_pow2_frac = 17'h129EA;
			5'h08: pdbm_pow2_frac = 17'h13070;
			5'h09: pdbm_pow2_frac = 17'h1371A;
			5'h0A: pdbm_pow2_frac = 17'h13DEA;
			5'h0B: pdbm_pow2_frac = 17'h144E0;
			5'h0C: pdbm_pow2_frac = 17'h14BFE;
			5'h0D: pdbm_pow2_frac = 17'h15343;
			5'h0E: pdbm_pow2_frac = 17'h15AB0;
			5'h0F: pdbm_pow2_frac = 17'h16248;
			5'h10: pdbm_pow2_frac = 17'h16A0A;
			5'h11: pdbm_pow2_frac = 17'h171F7;
			5'h12: pdbm_pow2_frac = 17'h17A11;
			5'h13: pdbm_pow2_frac = 17'h18259;
			5'h14: pdbm_pow2_frac = 17'h18ACE;
			5'h15: pdbm_pow2_frac = 17'h19373;
			5'h16: pdbm_pow2_frac = 17'h19C49;
			5'h17: pdbm_pow2_frac = 17'h1A550;
			5'h18: pdbm_pow2_frac = 17'h1AE8A;
			5'h19: pdbm_pow2_frac = 17'h1B7F7;
			5'h1A: pdbm_pow2_frac = 17'h1C199;
			5'h1B: pdbm_pow2_frac = 17'h1CB72;
			5'h1C: pdbm_pow2_frac = 17'h1D581;
			5'h1D: pdbm_pow2_frac = 17'h1DFC9;
			5'h1E: pdbm_pow2_frac = 17'h1EA4B;
			default: pdbm_pow2_frac = 17'h1F507;
		endcase
	endfunction : pdbm_pow2_frac

	// Registered read keeps the table out of the multiplier path.
	always_ff @(posedge clk) begin
		rdata <= pdbm_pow2_frac(addr);
	end

endmodule : pdbm_exp_rom

// File: design/pdbm_mapper.sv
`timescale 1ns/1ps
`include "pdbm_defines.svh"

module pdbm_mapper #(
	parameter int TMO_SLOW_CYC = `PDBM_TMO_SLOW_US * `PDBM_CLK_FREQ_MHZ,
	parameter int TMO_MID_CYC = `PDBM_TMO_MID_US * `PDBM_CLK_FREQ_MHZ,
	parameter int TMO_FAST_CYC = `PDBM_TMO_FAST_US * `PDBM_CLK_FREQ_MHZ
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr_en,
	output logic [7:0] reg_rdata,
	input wire logic pwm_in,
	input wire logic pwm_enable,
	input wire logic exp_mapping_sel,
	input wire pdbm_pkg::pdbm_src_t code_source,
	input wire logic [10:0] brightness_code_word,
	output logic [10:0] pwm_duty_code,
	output logic pwm_timeout,
	output logic [24:0] sink_target_current
);

	// ==========================================================
	// Functions
	function automatic logic [19:0] pdbm_sat_inc(input logic [19:0] v, input logic add);
		pdbm_sat_inc = (add && v != 20'hFFFFF) ? v + 20'h00001 : v;
	endfunction : pdbm_sat_inc

	// Setting n needs 2^n codes; the unused code 111 acts as 110.
	function automatic logic [10:0] pdbm_hyst_steps(input logic [2:0] s);
		pdbm_hyst_steps = (s == 3'h7) ? 11'h040 : (11'h001 << s);
	endfunction : pdbm_hyst_steps

	// ==========================================================
	// Reset release and pin synchroniser
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic [2:0] pin_sync_reg;
	logic pwm_level_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// A change is accepted only once the second and third stages agree.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync_reg <= 3'h0;
			pwm_level_reg <= 1'b0;
		end else begin
			pin_sync_reg <= {pin_sync_reg[1:0], pwm_in};
			if (pin_sync_reg[1] == pin_sync_reg[2]) begin
				pwm_level_reg <= pin_sync_reg[2];
			end
		end
	end

	// ==========================================================
	// Configuration register
	logic [7:0] cfg_reg;
	wire cfg_hit = (reg_addr == `PDBM_REG_PWM_CFG);
	wire [1:0] rate_sel = cfg_reg[`PDBM_CFG_RATE_HI:`PDBM_CFG_RATE_LO];
	wire [2:0] hyst_sel = cfg_reg[`PDBM_CFG_HYST_HI:`PDBM_CFG_HYST_LO];

	// Reserved bits are never stored, so they read back as zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= `PDBM_CFG_RESET;
			reg_rdata <= 8'h00;
		end else begin
			if (reg_wr_en && cfg_hit) begin
				cfg_reg <= reg_wdata & `PDBM_CFG_WR_MASK;
			end
			reg_rdata <= cfg_hit ? cfg_reg : 8'h00;
		end
	end

	// ==========================================================
	// Sample-rate enable: a phase accumulator gives exact average rates.
	logic [9:0] rate_acc_reg;
	wire [9:0] rate_inc = rate_sel[1] ? `PDBM_RATE_INC_FAST :
		(rate_sel[0] ? `PDBM_RATE_INC_MID : `PDBM_RATE_INC_SLOW);
	// One spare bit: the fastest increment can carry the sum past the 10-bit range.
	wire [10:0] rate_sum = {1'b0, rate_acc_reg} + {1'b0, rate_inc};
	wire sample_tick = (rate_sum >= {1'b0, `PDBM_RATE_ACC_WRAP});

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rate_acc_reg <= 10'h000;
		end else begin
			rate_acc_reg <= sample_tick ? 10'(rate_sum - {1'b0, `PDBM_RATE_ACC_WRAP}) : rate_sum[9:0];
		end
	end

	// ==========================================================
	// Period measurement: count high and total samples per period.
	logic samp_prev_reg;
	logic edge_seen_reg;
	logic [19:0] high_cnt_reg;
	logic [19:0] total_cnt_reg;
	wire rise = sample_tick && pwm_level_reg && !samp_prev_reg && pwm_enable;
	wire period_done = rise && edge_seen_reg;
	// Timeout state is declared here because the measurement restarts on it.
	logic [21:0] tmo_cnt_reg;
	logic tmo_reg;
	wire [21:0] tmo_limit = rate_sel[1] ? 22'(TMO_FAST_CYC) :
		(rate_sel[0] ? 22'(TMO_MID_CYC) : 22'(TMO_SLOW_CYC));
	// A rise in the same cycle means a pulse was seen, so no timeout is reported.
	wire tmo_fire = pwm_enable && !tmo_reg && !rise && (tmo_cnt_reg >= tmo_limit);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			samp_prev_reg <= 1'b0;
			edge_seen_reg <= 1'b0;
			high_cnt_reg <= 20'h00000;
			total_cnt_reg <= 20'h00000;
		end else if (!pwm_enable || tmo_fire) begin
			edge_seen_reg <= 1'b0;
			samp_prev_reg <= pwm_level_reg;
		end else if (sample_tick) begin
			samp_prev_reg <= pwm_level_reg;
			edge_seen_reg <= edge_seen_reg | rise;
			high_cnt_reg <= rise ? 20'h00001 : pdbm_sat_inc(high_cnt_reg, pwm_level_reg);
			total_cnt_reg <= rise ? 20'h00001 : pdbm_sat_inc(total_cnt_reg, 1'b1);
		end
	end

	// ==========================================================
	// Missing-pulse timeout, counted in system clocks.
	// pulse timeout
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tmo_cnt_reg <= 22'h000000;
			tmo_reg <= 1'b0;
		end else if (!pwm_enable || rise) begin
			tmo_cnt_reg <= 22'h000000;
			tmo_reg <= 1'b0;
		end else begin
			tmo_cnt_reg <= tmo_reg ? tmo_cnt_reg : tmo_cnt_reg + 22'h000001;
			tmo_reg <= tmo_reg | tmo_fire;
		end
	end
	assign pwm_timeout = tmo_reg;

	// ==========================================================
	// Serial divider: code = floor(high * 2048 / total), one bit a clock.
	pdbm_pkg::pdbm_div_state_t div_state_reg;
	logic [20:0] div_rem_reg;
	logic [19:0] div_den_reg;
	logic [10:0] div_q_reg;
	logic [3:0] div_cnt_reg;
	logic div_done_reg;
	wire [20:0] rem_shift = {div_rem_reg[19:0], 1'b0};
	wire rem_ge = (rem_shift >= {1'b0, div_den_reg});
	wire full_duty = (high_cnt_reg == total_cnt_reg);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_state_reg <= pdbm_pkg::PDBM_DIV_IDLE;
			div_rem_reg <= 21'h000000;
			div_den_reg <= 20'h00000;
			div_q_reg <= 11'h000;
			div_cnt_reg <= 4'h0;
			div_done_reg <= 1'b0;
		end else begin
			div_done_reg <= 1'b0;
			case (div_state_reg)
				pdbm_pkg::PDBM_DIV_IDLE: begin
					if (period_done && full_duty) begin
						div_q_reg <= `PDBM_CODE_MAX;
						div_done_reg <= 1'b1;
					end else if (period_done) begin
						div_rem_reg <= {1'b0, high_cnt_reg};
						div_den_reg <= total_cnt_reg;
						div_cnt_reg <= 4'h0;
						div_state_reg <= pdbm_pkg::PDBM_DIV_RUN;
					end
				end
				pdbm_pkg::PDBM_DIV_RUN: begin
					div_rem_reg <= rem_ge ? rem_shift - {1'b0, div_den_reg} : rem_shift;
					div_q_reg <= {div_q_reg[9:0], rem_ge};
					div_cnt_reg <= div_cnt_reg + 4'h1;
					if (div_cnt_reg == 4'hA) begin
						div_done_reg <= 1'b1;
						div_state_reg <= pdbm_pkg::PDBM_DIV_IDLE;
					end
				end
				default: div_state_reg <= pdbm_pkg::PDBM_DIV_IDLE;
			endcase
		end
	end

	// A timeout reports a steady level: high is full duty, low is zero.
	wire meas_valid = div_done_reg || tmo_fire;
	wire [10:0] meas_code = tmo_fire ? (pwm_level_reg ? `PDBM_CODE_MAX : 11'h000) : div_q_reg;

	// ==========================================================
	// Direction hysteresis on the PWM code.
	logic [10:0] pwm_code_reg;
	logic dir_up_reg;
	wire [10:0] hyst_thr = pdbm_hyst_steps(hyst_sel);
	wire meas_up = meas_code > pwm_code_reg;
	wire meas_dn = meas_code < pwm_code_reg;
	wire [10:0] delta = meas_up ? meas_code - pwm_code_reg : pwm_code_reg - meas_code;
	wire reversal = (meas_up && !dir_up_reg) || (meas_dn && dir_up_reg);
	wire accept = meas_valid && (meas_up || meas_dn) && (!reversal || delta >= hyst_thr);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_code_reg <= 11'h000;
			dir_up_reg <= 1'b1;
		end else if (accept) begin
			pwm_code_reg <= meas_code;
			dir_up_reg <= meas_up;
		end
	end
	assign pwm_duty_code = pwm_code_reg;

	// ==========================================================
	// Code selection; the product scales the bus code by (duty+1)/2048.
	wire [21:0] prod_full = {11'h000, brightness_code_word} * {10'h000, 12'(pwm_code_reg) + 12'h001};
	wire [10:0] code_sel = (code_source == pdbm_pkg::PDBM_SRC_PWM) ? pwm_code_reg :
		(code_source == pdbm_pkg::PDBM_SRC_PRODUCT) ? prod_full[21:11] : brightness_code_word;

	// ==========================================================
	// Mapper stage A: split code*log2(base) into integer and fraction.
	logic [10:0] code_a_reg;
	logic [3:0] int_a_reg;
	logic [10:0] rem_a_reg;
	logic [16:0] pow_frac;
	wire [19:0] exp_e = {9'h000, code_sel} * `PDBM_EXP_LOG2_Q16;

	pdbm_exp_rom u_rom (
		.clk(clk),
		.addr(exp_e[15:11]),
		.rdata(pow_frac)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			code_a_reg <= 11'h000;
			int_a_reg <= 4'h0;
			rem_a_reg <= 11'h000;
		end else begin
			code_a_reg <= code_sel;
			int_a_reg <= exp_e[19:16];
			rem_a_reg <= exp_e[10:0];
		end
	end

	// ==========================================================
	// Mapper stage B: first-order interpolation between table points.
	wire [43:0] t_rem = {27'h0000000, pow_frac} * {33'h000000000, rem_a_reg};
	wire [59:0] t_ln = {16'h0000, t_rem} * `PDBM_LN2_Q16;
	wire [17:0] mant = {1'b0, pow_frac} + {1'b0, t_ln[48:32]};
	wire [47:0] exp_prod = {30'h00000000, mant} * `PDBM_EXP_BASE_NA;
	wire [47:0] exp_shift = exp_prod << int_a_reg;
	wire [24:0] exp_cur = exp_shift[40:16];
	wire [24:0] lin_cur = `PDBM_LIN_OFFSET_NA + 25'(code_a_reg) * `PDBM_LIN_SLOPE_NA;
	wire [24:0] law_cur = exp_mapping_sel ? exp_cur : lin_cur;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sink_target_current <= 25'h0000000;
		end else begin
			sink_target_current <= (code_a_reg == 11'h000) ? 25'h0000000 : law_cur;
		end
	end

endmodule : pdbm_mapper

// File: design/pdbm_pkg.sv
package pdbm_pkg;

	// ==========================================================
	// Source of the code handed to the current mapper.
	typedef enum logic [1:0] {
		PDBM_SRC_BUS = 2'h0,
		PDBM_SRC_PWM = 2'h1,
		PDBM_SRC_PRODUCT = 2'h2
	} pdbm_src_t;

	// Duty divider sequencer, one-hot.
	typedef enum logic [1:0] {
		PDBM_DIV_IDLE = 2'h1,
		PDBM_DIV_RUN = 2'h2
	} pdbm_div_state_t;

endpackage : pdbm_pkg

// File: tb/pdbm_mapper_monitor.sv
`timescale 1ns/1ps

// ==========================================================
// Port checker for the duty-to-current mapper.
module pdbm_mapper_monitor #(
	parameter int TMO_SLOW_CYC = 2500000,
	parameter int TMO_MID_CYC = 300000,
	parameter int TMO_FAST_CYC = 60000
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_rdata,
	input wire logic pwm_in,
	input wire logic pwm_enable,
	input wire logic exp_mapping_sel,
	input wire pdbm_pkg::pdbm_src_t code_source,
	input wire logic [10:0] brightness_code_word,
	input wire logic [10:0] pwm_duty_code,
	input wire logic pwm_timeout,
	input wire logic [24:0] sink_target_current
);
	logic [3:0] up_cnt;
	logic ready;
	logic pin_last;
	int quiet_cnt;
	logic [22:0] prod;
	logic [10:0] sel;
	logic [24:0] lin_na;
	logic [1:0] rate_bits;
	int lim_now;
	// Skip edges while the internal reset copy is still held.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) up_cnt <= 4'h0;
		else if (!ready) up_cnt <= up_cnt + 4'h1;
	end
	// Cycles since the last rising pin edge; falling edges do not restart the timer.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			quiet_cnt <= 0;
			pin_last <= 1'b0;
			rate_bits <= 2'h0;
		end else begin
			pin_last <= pwm_in;
			// The rate is followed from bus writes, since only ports are visible here.
			if (reg_wr_en && reg_addr == 8'h12) rate_bits <= reg_wdata[7:6];
			if (!pwm_enable || (pwm_in && !pin_last)) quiet_cnt <= 0;
			else if (quiet_cnt < 32'h00FFFFFF) quiet_cnt <= quiet_cnt + 1;
		end
	end
	// Code the mapper should be working on, and its linear current.
	assign ready = (up_cnt == 4'h6);
	assign lim_now = rate_bits[1] ? TMO_FAST_CYC : (rate_bits[0] ? TMO_MID_CYC : TMO_SLOW_CYC);
	assign prod = brightness_code_word * ({1'b0, pwm_duty_code} + 12'h001);
	assign sel = (code_source == pdbm_pkg::PDBM_SRC_PWM) ? pwm_duty_code :
		(code_source == pdbm_pkg::PDBM_SRC_PRODUCT) ? prod[21:11] : brightness_code_word;
	assign lin_na = 25'h00093AE + 25'h0002FA3 * {14'h0000, sel};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_lin_current: assert property (
		(ready && !exp_mapping_sel && sel != 11'h000 && $stable(sel) && $stable(code_source))[*3]
		|-> sink_target_current == lin_na) else $error("linear current wrong");
	a_zero_code: assert property (
		(ready && sel == 11'h000 && $stable(code_source) && $stable(exp_mapping_sel))[*3]
		|-> sink_target_current == 25'h0000000) else $error("code zero drives current");
	a_exp_span: assert property (
		(ready && exp_mapping_sel && sel != 11'h000 && $stable(sel) && $stable(code_source))[*3]
		|-> sink_target_current >= 25'h000C350 && sink_target_current <= 25'h17F0000)
		else $error("exponential current out of span");
	a_cfg_readback: assert property (
		(ready && reg_wr_en && reg_addr == 8'h12) ##1 (reg_addr == 8'h12 && !reg_wr_en)
		|=> reg_rdata == ($past(reg_wdata, 2) & 8'hDC)) else $error("config readback wrong");
	a_unmapped_zero: assert property (
		(ready && reg_addr != 8'h12) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_enable_clear: assert property (
		(!pwm_enable)[*2] |-> !pwm_timeout) else $error("timeout while disabled");
	a_timeout_late: assert property (
		$rose(pwm_timeout) |-> quiet_cnt >= lim_now) else $error("timeout too early");
	a_timeout_due: assert property (
		(ready && pwm_enable && quiet_cnt >= lim_now + 200) |-> pwm_timeout)
		else $error("timeout missing");
endmodule : pdbm_mapper_monitor

bind pdbm_mapper pdbm_mapper_monitor #(.TMO_SLOW_CYC(TMO_SLOW_CYC), .TMO_MID_CYC(TMO_MID_CYC),
	.TMO_FAST_CYC(TMO_FAST_CYC))
	u_monitor (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr_en(reg_wr_en), .reg_rdata(reg_rdata), .pwm_in(pwm_in), .pwm_enable(pwm_enable),
	.exp_mapping_sel(exp_mapping_sel), .code_source(code_source),
	.brightness_code_word(brightness_code_word), .pwm_duty_code(pwm_duty_code),
	.pwm_timeout(pwm_timeout), .sink_target_current(sink_target_current));

// File: tb/pdbm_pwm_source.sv
`timescale 1ns/1ps

// ==========================================================
// Far-side PWM source; it idles at a chosen level between bursts.
module pdbm_pwm_source (
	input wire logic clk,
	input wire logic run,
	input wire logic idle_level,
	input wire integer period,
	input wire integer high_cyc,
	output logic pwm
);
	int cnt = 0;
	// period kept in range
	// Periods are set by the bench to 2000 cycles (PER) only.
	always @(negedge clk) begin
		if (!run) begin
			cnt <= 0;
			pwm <= idle_level;
		end else begin
			cnt <= (cnt + 1 >= period) ? 0 : cnt + 1;
			pwm <= (cnt < high_cyc);
		end
	end
endmodule : pdbm_pwm_source

// File: tb/pwm_duty_brightness_mapper_tb_top.sv
`timescale 1ns/1ps

`define CHK(a, b) \
	begin \
		checks_done++; \
		if ((a) !== (b)) begin \
			err_count++; \
			$display("ERROR at %0t: got %0h expected %0h", $time, (a), (b)); \
		end \
	end

// ==========================================================
// Self-checking bench; timeouts are shortened so the run stays brief.
module pwm_duty_brightness_mapper_tb_top;
	localparam int PER = 2000;
	int lim [3] = '{12000, 6000, 3000};
	int duty [4] = '{50, 52, 60, 62};
	logic [10:0] corners [3] = '{11'h000, 11'h001, 11'h7FF};
	logic clk, arst_n, reg_wr_en, pwm_in, pwm_enable, exp_mapping_sel, pwm_timeout;
	logic pwm_run, pwm_idle;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	pdbm_pkg::pdbm_src_t code_source;
	logic [10:0] brightness_code_word, pwm_duty_code, b, held;
	logic [24:0] sink_target_current;
	int pwm_period, pwm_high, i, n, cycles, err_count, checks_done;

	pdbm_mapper #(.TMO_SLOW_CYC(12000), .TMO_MID_CYC(6000), .TMO_FAST_CYC(3000)) u_dut (
		.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr_en(reg_wr_en), .reg_rdata(reg_rdata), .pwm_in(pwm_in),
		.pwm_enable(pwm_enable), .exp_mapping_sel(exp_mapping_sel),
		.code_source(code_source), .brightness_code_word(brightness_code_word),
		.pwm_duty_code(pwm_duty_code), .pwm_timeout(pwm_timeout),
		.sink_target_current(sink_target_current));
	pdbm_pwm_source u_src (.clk(clk), .run(pwm_run), .idle_level(pwm_idle),
		.period(pwm_period), .high_cyc(pwm_high), .pwm(pwm_in));

	function automatic logic [24:0] lin_na(input logic [10:0] c);
		lin_na = (c == 11'h000) ? 25'h0000000 : 25'h00093AE + 25'h0002FA3 * c;
	endfunction : lin_na
	function automatic logic near(input logic [24:0] a, input real e, input real tol);
		near = ($itor(a) >= e - tol) && ($itor(a) <= e + tol);
	endfunction : near
	task automatic results();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge clk);
		reg_wr_en = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		repeat (2) @(negedge clk);
		`CHK(reg_rdata, e)
	endtask : rd
	// Expected code c is given apart from the bus code, so product cases reuse the task.
	task automatic map(input logic e, input pdbm_pkg::pdbm_src_t s, input logic [10:0] bc,
		input logic [10:0] c);
		real ev;
		@(negedge clk);
		exp_mapping_sel = e;
		code_source = s;
		brightness_code_word = bc;
		repeat (3) @(negedge clk);
		ev = 50000.0 * (1.003040572 ** c);
		if (!e || c == 11'h000) `CHK(sink_target_current, lin_na(c))
		else `CHK(near(sink_target_current, ev, ev * 0.002), 1'b1)
	endtask : map

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// A hang is cut short and counted as a mismatch.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			err_count++;
			results();
		end
	end
	initial begin
		{arst_n, reg_wr_en, pwm_enable, exp_mapping_sel, pwm_run, pwm_idle} = 6'h00;
		{reg_addr, reg_wdata, brightness_code_word} = 27'h0000000;
		code_source = pdbm_pkg::PDBM_SRC_BUS;
		pwm_period = PER;
		pwm_high = PER / 2;
		void'($urandom(67));
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
		rd(8'h12, 8'h00);
		wr(8'h12, 8'hFF);
		rd(8'h12, 8'hDC);
		wr(8'h13, 8'h55);
		rd(8'h13, 8'h00);
		rd(8'h12, 8'hDC);
		// both laws over corner and random codes
		for (i = 0; i < 36; i++) begin
			b = (i < 6) ? corners[i % 3] : 11'($urandom);
			map(i[0], pdbm_pkg::PDBM_SRC_BUS, b, b);
		end
		// each rate tried, slowest first; timeout follows the rate
		pwm_enable = 1'b1;
		for (i = 0; i < 3; i++) begin
			wr(8'h12, 8'(i << 6));
			pwm_idle <= 1'b1;
			repeat (300) @(negedge clk);
			pwm_idle <= 1'b0;
			for (n = 300; pwm_timeout !== 1'b1 && n < lim[i] + 500; n++) @(negedge clk);
			`CHK(n >= lim[i] && n <= lim[i] + 400, 1'b1)
		end
		// steady high reads as full duty
		pwm_idle <= 1'b1;
		repeat (3300) @(negedge clk);
		`CHK(pwm_timeout, 1'b1)
		`CHK(pwm_duty_code, 11'h7FF)
		b = 11'($urandom);
		map(1'b0, pdbm_pkg::PDBM_SRC_PRODUCT, b, b);
		map(1'b1, pdbm_pkg::PDBM_SRC_PWM, b, 11'h7FF);
		// setting 110 suits about 0.6 us of jitter at 50 kHz
		wr(8'h12, 8'hD8);
		for (i = 0; i < 4; i++) begin
			pwm_high <= PER * duty[i] / 100;
			pwm_run <= 1'b1;
			repeat (4 * PER) @(negedge clk);
			if (i == 1) `CHK(pwm_duty_code, held)
			else `CHK(near(pwm_duty_code, 20.48 * duty[i], 10.0), 1'b1)
			held = pwm_duty_code;
		end
		results();
	end
endmodule : pwm_duty_brightness_mapper_tb_top
